// file: src/stack_interrupt_timer.v
`timescale 1ns/1ns
`include "flow_map.vh"
module stack_interrupt_timer (
   // clock and reset
   input wire clk,
   input wire resetn,
   // machine cycle strobe and instruction boundary
   input wire cycle_stb,
   input wire instr_done,
   input wire second_cycle,
   input wire large_variant,
   // program counter control
   input wire pc_inc,
   input wire pc_load,
   input wire [10:0] pc_load_val,
   input wire call_cmd,
   input wire plain_return,
   input wire restoring_return,
   // status word access
   input wire psw_write,
   input wire [7:0] psw_wdata,
   input wire user_flag_one,
   // stack ram interface
   output reg stack_we_r,
   output reg [4:0] stack_addr_r,
   output reg [15:0] stack_wdata_r,
   input wire [15:0] stack_rdata,
   // conditional branch
   input wire [3:0] cond_sel,
   input wire [7:0] accumulator,
   input wire [2:0] acc_bit_sel,
   input wire test_input_zero,
   input wire jump_on_timer_flag,
   output reg cond_true,
   // interrupt commands and pin
   input wire external_irq_enable_cmd,
   input wire external_irq_disable_cmd,
   input wire timer_irq_enable_cmd,
   input wire timer_irq_disable_cmd,
   input wire int_n,
   // timer commands and pin
   input wire timer_start_cmd,
   input wire event_mode_start_cmd,
   input wire counter_halt_cmd,
   input wire counter_load_cmd,
   input wire event_test_input,
   // outputs
   output reg [10:0] pc_r,
   output reg [10:0] onchip_addr_r,
   output reg ext_fetch_r,
   output wire [7:0] processor_status_word,
   output wire [7:0] counter_value,
   output reg timer_flag_r,
   output reg irq_taken_r
);
   localparam S_RUN = 3'b001;
   localparam S_PUSH = 3'b010;
   localparam S_POP = 3'b100;
   reg [2:0] state_r;
   reg [2:0] sp_r;
   reg [3:0] upper_r;
   reg bank_unused_r;
   reg int_s_r;
   reg ext_en_r;
   reg tmr_en_r;
   reg tmr_pend_r;
   reg in_service_r;
   reg [10:0] vec_r;
   reg ret_restore_r;
   reg push_int_r;
   wire wrap;
   wire [2:0] sp_dec;
   wire ext_req;
   wire tmr_req;
   wire take_int;
   wire [10:0] pc_nxt;
   event_counter u_cnt (
      .clk(clk),
      .resetn(resetn),
      .cycle_stb(cycle_stb),
      .timer_start_cmd(timer_start_cmd),
      .event_mode_start_cmd(event_mode_start_cmd),
      .counter_halt_cmd(counter_halt_cmd),
      .counter_load_cmd(counter_load_cmd),
      .load_data(accumulator),
      .event_test_input(event_test_input),
      .count_r(counter_value),
      .wrap_pulse(wrap)
   );
   // upper bits: cy ac f0 bank; bit 3 reads one
   assign processor_status_word = {upper_r, 1'b1, sp_r};
   assign sp_dec = sp_r - 3'd1;
   assign pc_nxt = (pc_r == `PC_MAX) ? `PC_RESET : pc_r + 11'd1;
   // level sampled once per machine cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         int_s_r <= 1'b1;
      else if (cycle_stb)
         int_s_r <= int_n;
   end
   assign ext_req = ext_en_r && !int_s_r && !in_service_r;
   assign tmr_req = tmr_en_r && tmr_pend_r && !in_service_r;
   assign take_int = state_r == S_RUN && instr_done &&
                     (ext_req || tmr_req);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_RUN;
         pc_r <= `PC_RESET;
         sp_r <= `SP_RESET;
         upper_r <= 4'h0;
         bank_unused_r <= 1'b0;
         ext_en_r <= 1'b0;
         tmr_en_r <= 1'b0;
         tmr_pend_r <= 1'b0;
         timer_flag_r <= 1'b0;
         in_service_r <= 1'b0;
         vec_r <= `PC_RESET;
         ret_restore_r <= 1'b0;
         push_int_r <= 1'b0;
         stack_we_r <= 1'b0;
         stack_addr_r <= `STACK_BASE;
         stack_wdata_r <= 16'h0000;
         irq_taken_r <= 1'b0;
      end else begin
         stack_we_r <= 1'b0;
         irq_taken_r <= 1'b0;
         if (external_irq_enable_cmd)
            ext_en_r <= 1'b1;
         else if (external_irq_disable_cmd)
            ext_en_r <= 1'b0;
         if (timer_irq_enable_cmd)
            tmr_en_r <= 1'b1;
         else if (timer_irq_disable_cmd)
            tmr_en_r <= 1'b0;
         // set wins over clear
         if (wrap)
            timer_flag_r <= 1'b1;
         else if (jump_on_timer_flag)
            timer_flag_r <= 1'b0;
         if (wrap && !timer_irq_disable_cmd)
            tmr_pend_r <= 1'b1;
         else if (timer_irq_disable_cmd)
            tmr_pend_r <= 1'b0;
         if (psw_write && state_r == S_RUN) begin
            upper_r <= psw_wdata[7:4];
            sp_r <= psw_wdata[2:0];
         end
         if (in_service_r && ret_restore_r && second_cycle)
            in_service_r <= 1'b0;
         case (state_r)
            S_RUN: begin
               if (take_int) begin
                  state_r <= S_PUSH;
                  push_int_r <= 1'b1;
                  in_service_r <= 1'b1;
                  // stale restore mark must not reopen the window
                  ret_restore_r <= 1'b0;
                  irq_taken_r <= 1'b1;
                  if (ext_req)
                     vec_r <= `VEC_EXT;
                  else begin
                     vec_r <= `VEC_TMR;
                     if (!wrap)
                        tmr_pend_r <= 1'b0;
                  end
               end else if (call_cmd) begin
                  state_r <= S_PUSH;
                  push_int_r <= 1'b0;
                  vec_r <= pc_load_val;
               end else if (plain_return || restoring_return) begin
                  sp_r <= sp_dec;
                  // address the pair now so ram data stands in the pop cycle
                  stack_addr_r <= `STACK_BASE + {1'b0, sp_dec, 1'b0};
                  ret_restore_r <= restoring_return;
                  state_r <= S_POP;
               end else if (pc_load)
                  pc_r <= pc_load_val;
               else if (pc_inc)
                  pc_r <= pc_nxt;
            end
            S_PUSH: begin
               stack_we_r <= 1'b1;
               stack_addr_r <= `STACK_BASE + {1'b0, sp_r, 1'b0};
               stack_wdata_r <= {upper_r, 1'b0, pc_r};
               sp_r <= sp_r + 3'd1;
               pc_r <= vec_r;
               state_r <= S_RUN;
            end
            S_POP: begin
               pc_r <= stack_rdata[10:0];
               if (ret_restore_r)
                  upper_r <= stack_rdata[15:12];
               state_r <= S_RUN;
            end
            default: state_r <= S_RUN;
         endcase
      end
   end
   // on-chip address uses low ten bits only in the small variant; large variant uses all eleven
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         onchip_addr_r <= 11'h000;
         ext_fetch_r <= 1'b0;
      end else if (large_variant) begin
         onchip_addr_r <= pc_r;
         ext_fetch_r <= 1'b0;
      end else begin
         onchip_addr_r <= {1'b0, pc_r[9:0]};
         ext_fetch_r <= pc_r[10];
      end
   end
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         cond_true <= 1'b0;
      else begin
         case (cond_sel)
            `CND_ACC_ZERO: cond_true <= accumulator == 8'h00;
            `CND_ACC_NZ: cond_true <= accumulator != 8'h00;
            `CND_ACC_BIT: cond_true <= accumulator[acc_bit_sel];
            `CND_CY_CLR: cond_true <= !upper_r[3];
            `CND_CY_SET: cond_true <= upper_r[3];
            `CND_F0: cond_true <= upper_r[1];
            `CND_F1: cond_true <= user_flag_one;
            `CND_TF: cond_true <= timer_flag_r;
            `CND_T0_LO: cond_true <= !test_input_zero;
            `CND_T0_HI: cond_true <= test_input_zero;
            `CND_T1_LO: cond_true <= !event_test_input;
            `CND_T1_HI: cond_true <= event_test_input;
            `CND_INT_LO: cond_true <= !int_s_r;
            default: cond_true <= 1'b0;
         endcase
      end
   end
endmodule // stack_interrupt_timer

// file: shared/flow_map.vh
`ifndef FLOW_MAP_VH
`define FLOW_MAP_VH
// program counter
`define PC_W 11
`define PC_MAX 11'h7ff
`define PC_RESET 11'h000
`define ONCHIP_W_SMALL 10
`define ONCHIP_W_LARGE 11
// vectors
`define VEC_EXT 11'h003
`define VEC_TMR 11'h007
// status word fields
`define PSW_SP_LO 0
`define PSW_SP_HI 2
`define PSW_ONE 3
`define PSW_BANK 4
`define PSW_F0 5
`define PSW_AC 6
`define PSW_CY 7
`define PSW_RESET 8'h08
`define SP_RESET 3'h0
// stack area in data ram
`define STACK_BASE 5'h08
`define STACK_BYTES 16
// timer
`define CNT_MAX 8'hff
`define PRESCALE_DIV 32
`define PRESCALE_MAX 5'h1f
`define EVENT_MIN_CYCLES 3
// condition select codes
`define CND_ACC_ZERO 4'h0
`define CND_ACC_NZ 4'h1
`define CND_ACC_BIT 4'h2
`define CND_CY_CLR 4'h3
`define CND_CY_SET 4'h4
`define CND_F0 4'h5
`define CND_F1 4'h6
`define CND_TF 4'h7
`define CND_T0_LO 4'h8
`define CND_T0_HI 4'h9
`define CND_T1_LO 4'ha
`define CND_T1_HI 4'hb
`define CND_INT_LO 4'hc
`endif

// file: src/event_counter.v
`timescale 1ns/1ns
`include "flow_map.vh"
module event_counter (
   // clock and reset
   input wire clk,
   input wire resetn,
   // machine cycle strobe
   input wire cycle_stb,
   // control
   input wire timer_start_cmd,
   input wire event_mode_start_cmd,
   input wire counter_halt_cmd,
   input wire counter_load_cmd,
   input wire [7:0] load_data,
   // event pin, synchronous
   input wire event_test_input,
   // state
   output reg [7:0] count_r,
   output wire wrap_pulse
);
   localparam M_STOP = 3'b001;
   localparam M_TIMER = 3'b010;
   localparam M_EVENT = 3'b100;
   reg [2:0] mode_r;
   reg [4:0] presc_r;
   reg ev_s1_r;
   reg ev_s2_r;
   reg ev_prev_r;
   reg [1:0] holdoff_r;
   wire fall;
   wire tick;
   wire inc;
   // two-stage sample then edge compare
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ev_s1_r <= 1'b1;
         ev_s2_r <= 1'b1;
         ev_prev_r <= 1'b1;
      end else begin
         ev_s1_r <= event_test_input;
         ev_s2_r <= ev_s1_r;
         ev_prev_r <= ev_s2_r;
      end
   end
   assign fall = ev_prev_r & ~ev_s2_r;
   assign tick = cycle_stb && presc_r == `PRESCALE_MAX;
   assign inc = (mode_r == M_TIMER && tick) ||
                (mode_r == M_EVENT && fall && holdoff_r == 2'd0);
   assign wrap_pulse = inc && count_r == `CNT_MAX;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= M_STOP;
         presc_r <= 5'h00;
         holdoff_r <= 2'd0;
      end else begin
         if (counter_halt_cmd)
            mode_r <= M_STOP;
         else if (timer_start_cmd)
            mode_r <= M_TIMER;
         else if (event_mode_start_cmd)
            mode_r <= M_EVENT;
         if (timer_start_cmd)
            presc_r <= 5'h00;
         else if (cycle_stb)
            presc_r <= presc_r + 5'h01;
         if (inc && mode_r == M_EVENT)
            holdoff_r <= 2'd`EVENT_MIN_CYCLES;
         else if (cycle_stb && holdoff_r != 2'd0)
            holdoff_r <= holdoff_r - 2'd1;
      end
   end
   // counter value survives reset
   always @(posedge clk) begin
      if (counter_load_cmd)
         count_r <= load_data;
      else if (inc)
         count_r <= count_r + 8'h01;
   end
endmodule // event_counter

// file: bench/irq_source.sv
`timescale 1ns/1ns
module irq_source (
   // clock
   input wire clk,
   // requests from the bench
   input wire irq_req,
   input wire evt_go,
   // pins toward the block
   output logic int_n,
   output logic event_test_input
);
   logic [2:0] hold_r = 3'h0;
   logic [2:0] low_r = 3'h0;
   initial int_n = 1'b1;
   initial event_test_input = 1'b1;
   // request held low four clocks at least
   always @(posedge clk) begin
      if (irq_req) begin
         int_n <= 1'b0;
         hold_r <= 3'h4;
      end else if (hold_r != 3'h0) begin
         hold_r <= hold_r - 3'h1;
      end else begin
         int_n <= 1'b1;
      end
      if (evt_go) begin
         event_test_input <= 1'b0;
         low_r <= 3'h4;
      end else if (low_r != 3'h0) begin
         low_r <= low_r - 3'h1;
      end else begin
         event_test_input <= 1'b1;
      end
   end
endmodule // irq_source

// file: bench/stack_interrupt_timer_asserts.sv
`timescale 1ns/1ns
module stack_interrupt_timer_asserts (
   // clock and reset
   input wire clk,
   input wire resetn,
   // watched ports
   input wire call_cmd,
   input wire psw_write,
   input wire [7:0] psw_wdata,
   input wire [3:0] cond_sel,
   input wire test_input_zero,
   input wire jump_on_timer_flag,
   input wire counter_halt_cmd,
   input wire stack_we_r,
   input wire [4:0] stack_addr_r,
   input wire [15:0] stack_wdata_r,
   input wire cond_true,
   input wire [10:0] pc_r,
   input wire [7:0] processor_status_word,
   input wire [7:0] counter_value,
   input wire timer_flag_r,
   input wire irq_taken_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   pc_reset_a: assert property (
      $rose(resetn) |-> pc_r == 11'h000 && processor_status_word == 8'h08)
      else $error("reset state wrong");
   call_push_a: assert property (
      call_cmd |-> ##2 stack_we_r) else $error("call did not push");
   stack_slot_a: assert property (
      stack_we_r |-> stack_addr_r ==
         5'h08 + {1'b0, processor_status_word[2:0] - 3'h1, 1'b0})
      else $error("push slot wrong");
   stack_word_a: assert property (
      stack_we_r |-> stack_wdata_r[15:11] == {processor_status_word[7:4], 1'b0})
      else $error("pushed status wrong");
   psw_write_a: assert property (
      psw_write |-> ##2 processor_status_word == ($past(psw_wdata, 2) | 8'h08))
      else $error("status write wrong");
   irq_vector_a: assert property (
      irq_taken_r |=> pc_r == 11'h003 || pc_r == 11'h007)
      else $error("interrupt vector wrong");
   flag_wrap_a: assert property (
      $rose(timer_flag_r) |-> counter_value == 8'h00)
      else $error("flag set without wrap");
   flag_clear_a: assert property (
      jump_on_timer_flag |=> !timer_flag_r) else $error("flag not cleared");
   halt_hold_a: assert property (
      counter_halt_cmd |-> ##2 $stable(counter_value) [*8])
      else $error("halted counter moved");
   cond_t0_a: assert property (
      cond_sel == 4'h8 |=> cond_true == !$past(test_input_zero))
      else $error("test input condition wrong");
endmodule // stack_interrupt_timer_asserts

// file: bench/test_stack_interrupt_timer.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin \
   #1; \
   samples_checked++; \
   if ((s) !== (e)) begin \
      errors++; \
      $display("FAIL %s expected %h seen %h", n, e, s); \
   end \
end
`define DO(s) begin \
   @(posedge clk); \
   s <= 1'b1; \
   @(posedge clk); \
   s <= 1'b0; \
   repeat (3) @(posedge clk); \
end
module test_stack_interrupt_timer;
   logic clk = 0, resetn = 0, cycle_stb = 0, instr_done = 0, second_cycle = 0;
   logic large_variant = 0, pc_inc = 0, pc_load = 0, call_cmd = 0;
   logic plain_return = 0, restoring_return = 0, psw_write = 0;
   logic user_flag_one = 0, test_input_zero = 0, jump_on_timer_flag = 0;
   logic external_irq_enable_cmd = 0, external_irq_disable_cmd = 0;
   logic timer_irq_enable_cmd = 0, timer_irq_disable_cmd = 0, evt_go = 0;
   logic timer_start_cmd = 0, event_mode_start_cmd = 0, irq_req = 0;
   logic counter_halt_cmd = 0, counter_load_cmd = 0;
   logic [10:0] pc_load_val = 0, a;
   logic [7:0] psw_wdata = 0, accumulator = 0;
   logic [3:0] cond_sel = 0;
   logic [2:0] acc_bit_sel = 0;
   logic [31:0] v;
   logic [15:0] stk [0:31];
   wire stack_we_r, cond_true, int_n, event_test_input, ext_fetch_r;
   wire timer_flag_r, irq_taken_r;
   wire [4:0] stack_addr_r;
   wire [15:0] stack_wdata_r, stack_rdata;
   wire [10:0] pc_r, onchip_addr_r;
   wire [7:0] processor_status_word, counter_value;
   int seed = 12063, errors = 0, samples_checked = 0, irqs = 0, n;
   stack_interrupt_timer i_stack_interrupt_timer (.*);
   irq_source i_irq_source (.*);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycle_stb <= ~cycle_stb;
      instr_done <= ~cycle_stb;
      if (irq_taken_r === 1'b1)
         irqs <= irqs + 1;
      if (stack_we_r === 1'b1)
         stk[stack_addr_r] <= stack_wdata_r;
   end
   assign stack_rdata = stk[stack_addr_r];
   function automatic logic exp_cond(input logic [3:0] c);
      logic [15:0] t;
      t = {3'h0, ~int_n, event_test_input, ~event_test_input, test_input_zero,
         ~test_input_zero, 1'b0, user_flag_one, psw_wdata[5], psw_wdata[7],
         ~psw_wdata[7], accumulator[acc_bit_sel], |accumulator, ~|accumulator};
      return t[c];
   endfunction
   task automatic reti();
      @(posedge clk);
      restoring_return <= 1'b1;
      @(posedge clk);
      restoring_return <= 1'b0;
      second_cycle <= 1'b1;
      @(posedge clk);
      second_cycle <= 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic stop_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      `CHK("pc", 11'h000, pc_r)
      v = $random(seed);
      psw_wdata <= {v[7:3], 3'h7};
      `DO(psw_write)
      `CHK("psw", {v[7:4], 4'hf}, processor_status_word)
      pc_load_val <= 11'h7ff;
      `DO(pc_load)
      `DO(pc_inc)
      `CHK("pc", 11'h000, pc_r)
      a = v[26:16];
      pc_load_val <= a;
      `DO(pc_load)
      pc_load_val <= a ^ 11'h555;
      `DO(call_cmd)
      `CHK("pc", a ^ 11'h555, pc_r)
      `CHK("psw", {v[7:4], 4'h8}, processor_status_word)
      `CHK("stack", {v[7:4], 1'b0, a}, stk[22])
      psw_wdata <= 8'ha0;
      `DO(psw_write)
      `DO(plain_return)
      `CHK("pc", a, pc_r)
      `CHK("psw", 8'haf, processor_status_word)
      `DO(call_cmd)
      psw_wdata <= 8'h30;
      `DO(psw_write)
      `DO(restoring_return)
      `CHK("pc", a, pc_r)
      `CHK("psw", 8'haf, processor_status_word)
      for (int i = 0; i < 26; i++) begin
         v = $random(seed);
         cond_sel <= 4'(i % 13);
         accumulator <= (i < 13) ? 8'h00 : v[7:0];
         acc_bit_sel <= v[10:8];
         test_input_zero <= v[11];
         user_flag_one <= v[12];
         psw_wdata <= v[23:16];
         `DO(psw_write)
         `CHK("cond", exp_cond(cond_sel), cond_true)
      end
      irq_req <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK("irqs", 0, irqs)
      `DO(external_irq_enable_cmd)
      repeat (40) @(posedge clk);
      `CHK("irqs", 1, irqs)
      `CHK("pc", 11'h003, pc_r)
      `DO(timer_irq_enable_cmd)
      accumulator <= 8'hfe;
      `DO(counter_load_cmd)
      `CHK("count", 8'hfe, counter_value)
      `DO(timer_start_cmd)
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (counter_value !== 8'(k + 255) && n < 300) begin
            @(posedge clk);
            n++;
         end
      end
      `CHK("period", 64, n)
      `CHK("flag", 1'b1, timer_flag_r)
      reti();
      `CHK("pc", 11'h003, pc_r)
      `CHK("irqs", 2, irqs)
      irq_req <= 1'b0;
      repeat (10) @(posedge clk);
      reti();
      `CHK("pc", 11'h007, pc_r)
      `CHK("irqs", 3, irqs)
      `DO(jump_on_timer_flag)
      `CHK("flag", 1'b0, timer_flag_r)
      `DO(counter_halt_cmd)
      repeat (10) @(posedge clk);
      pc_load_val <= 11'h5a3;
      `DO(pc_load)
      `CHK("onchip", 11'h1a3, onchip_addr_r)
      `CHK("ext", 1'b1, ext_fetch_r)
      large_variant <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("onchip", 11'h5a3, onchip_addr_r)
      `CHK("ext", 1'b0, ext_fetch_r)
      accumulator <= 8'h10;
      `DO(counter_load_cmd)
      `DO(event_mode_start_cmd)
      repeat (3) begin
         `DO(evt_go)
         repeat (20) @(posedge clk);
      end
      `CHK("events", 8'h13, counter_value)
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      irq_req <= 1'b1;
      repeat (30) @(posedge clk);
      `CHK("count", 8'h13, counter_value)
      `CHK("pc", 11'h000, pc_r)
      `CHK("irqs", 3, irqs)
      stop_test();
   end
endmodule // test_stack_interrupt_timer
bind stack_interrupt_timer stack_interrupt_timer_asserts
   i_stack_interrupt_timer_asserts (.*);
